// ==== shared/ect_pkg.sv ====
// ect_pkg: shared constants, enumerations and carriers for the event counter and timer
// assumes a 40 MHz reference clock and software registers on a plain strobe port
package ect_pkg;

    // clock and microsecond tick
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned TICK_NS       = 1000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL     = 8'h00; // enables, sources, edges
    localparam logic [7:0] OFS_CMD      = 8'h04; // command strobes
    localparam logic [7:0] OFS_CNT_LIM  = 8'h08;
    localparam logic [7:0] OFS_CNT_NOW  = 8'h0c;
    localparam logic [7:0] OFS_CNT_SNAP = 8'h10;
    localparam logic [7:0] OFS_TMR_LEN  = 8'h14;
    localparam logic [7:0] OFS_TMR_ELAP = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1c;

    // control word field positions
    localparam int unsigned F_CNT_BEGIN = 0;  // 4 bits
    localparam int unsigned F_CNT_CLEAR = 4;  // 4 bits
    localparam int unsigned F_CNT_STEP  = 8;  // 4 bits
    localparam int unsigned F_CNT_CEDGE = 12; // 2 bits
    localparam int unsigned F_CNT_SEDGE = 14; // 2 bits
    localparam int unsigned F_TMR_SRC   = 16; // 4 bits
    localparam int unsigned F_TMR_EDGE  = 20; // 2 bits
    localparam int unsigned F_TMR_EN    = 24; // 1 bit
    localparam int unsigned F_CNT_EN    = 25; // 1 bit

    // command bits
    localparam int unsigned C_CNT_CLEAR = 0;
    localparam int unsigned C_TMR_CLEAR = 1;

    // reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RST = 32'hffff_ffff;

    // event sources, shared by every selector
    typedef enum logic [3:0] {
        SRC_OFF, SRC_EXP_BEGIN, SRC_EXP_FINISH, SRC_RD_BEGIN, SRC_RD_FINISH,
        SRC_FRAME_BEGIN, SRC_FRAME_OK, SRC_INPUT_A, SRC_INPUT_B,
        SRC_TMR_DONE, SRC_CNT_DONE, SRC_TICK
    } ect_src_t;

    typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_ANY} ect_edge_t;

    typedef enum logic [1:0] {
        TMR_STATE_IDLE, TMR_STATE_ARMED, TMR_STATE_RUNNING, TMR_STATE_DONE
    } ect_tmr_state_t;

    // internal imaging events, one-cycle pulses
    typedef struct packed {
        logic exposure_begin_event;
        logic exposure_finish_event;
        logic readout_begin_event;
        logic readout_finish_event;
        logic frame_begin_event;
        logic accepted_frame_trigger;
    } ect_events_t;

    // software register port
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ect_reg_req_t;

endpackage

// ==== src/ect_core.sv ====
// ect_core: event counter and microsecond timer with its register file
// assumes imaging events are ref_clk pulses and input lines are asynchronous pins
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module ect_core (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // register port
    input  wire ect_pkg::ect_reg_req_t reg_req,
    output logic [31:0]               reg_rdata,
    // event sources
    input  wire ect_pkg::ect_events_t imaging_events,
    input  wire logic                 io_input_a,
    input  wire logic                 io_input_b,
    // events out
    output logic                      tmr_done_event,
    output logic                      count_done_event,
    output logic                      tmr_pulse
);

    // registers
    logic [31:0]            ctrl_q;
    logic [31:0]            count_limit_q;
    logic [31:0]            tmr_pulse_length_q;
    logic [31:0]            count_now_q;
    logic [31:0]            count_snapshot_q;
    logic [31:0]            tmr_elapsed_q;
    logic                   counting_q;
    ect_pkg::ect_tmr_state_t tmr_state_q;
    logic [15:0]            presc_q;
    logic                   tick_q;
    logic [2:0]             line_a_q;
    logic [2:0]             line_b_q;
    logic                   tmr_done_q;
    logic                   cnt_done_q;

    // decoded fields
    ect_pkg::ect_src_t count_begin_source;
    ect_pkg::ect_src_t count_clear_source;
    ect_pkg::ect_src_t count_step_source;
    ect_pkg::ect_edge_t count_clear_edge;
    ect_pkg::ect_edge_t count_step_edge;
    ect_pkg::ect_src_t tmr_launch_source;
    ect_pkg::ect_edge_t tmr_launch_edge;
    logic              tmr_enable_setting;
    logic              cnt_enable;
    logic              count_clear_cmd;
    logic              tmr_clear_cmd;
    logic              a_rise, a_fall, b_rise, b_fall;
    logic              cnt_step, cnt_reset_evt, cnt_begin_evt, tmr_launch;
    logic              self_restart, cnt_at_limit;

    assign count_begin_source = ect_pkg::ect_src_t'(ctrl_q[ect_pkg::F_CNT_BEGIN +: 4]);
    assign count_clear_source = ect_pkg::ect_src_t'(ctrl_q[ect_pkg::F_CNT_CLEAR +: 4]);
    assign count_step_source  = ect_pkg::ect_src_t'(ctrl_q[ect_pkg::F_CNT_STEP +: 4]);
    assign count_clear_edge   = ect_pkg::ect_edge_t'(ctrl_q[ect_pkg::F_CNT_CEDGE +: 2]);
    assign count_step_edge    = ect_pkg::ect_edge_t'(ctrl_q[ect_pkg::F_CNT_SEDGE +: 2]);
    assign tmr_launch_source  = ect_pkg::ect_src_t'(ctrl_q[ect_pkg::F_TMR_SRC +: 4]);
    assign tmr_launch_edge    = ect_pkg::ect_edge_t'(ctrl_q[ect_pkg::F_TMR_EDGE +: 2]);
    assign tmr_enable_setting = ctrl_q[ect_pkg::F_TMR_EN];
    assign cnt_enable         = ctrl_q[ect_pkg::F_CNT_EN];

    // command strobes are write-only pulses
    assign count_clear_cmd = reg_req.wr && reg_req.addr == ect_pkg::OFS_CMD
                             && reg_req.wdata[ect_pkg::C_CNT_CLEAR];
    assign tmr_clear_cmd   = reg_req.wr && reg_req.addr == ect_pkg::OFS_CMD
                             && reg_req.wdata[ect_pkg::C_TMR_CLEAR];

    // microsecond prescaler
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc_q <= 16'h0000;
            tick_q  <= 1'b0;
        end else if (presc_q == 16'(ect_pkg::TICK_CYCLES - 1)) begin
            presc_q <= 16'h0000;
            tick_q  <= 1'b1;
        end else begin
            presc_q <= presc_q + 16'h0001;
            tick_q  <= 1'b0;
        end
    end

    // two-flop synchronisers plus one history stage per line
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_a_q <= 3'h0;
            line_b_q <= 3'h0;
        end else begin
            line_a_q <= {line_a_q[1:0], io_input_a};
            line_b_q <= {line_b_q[1:0], io_input_b};
        end
    end

    // edges read only the second and third stages
    assign a_rise = line_a_q[1] && !line_a_q[2];
    assign a_fall = !line_a_q[1] && line_a_q[2];
    assign b_rise = line_b_q[1] && !line_b_q[2];
    assign b_fall = !line_b_q[1] && line_b_q[2];

    // pick one source pulse with edge qualification for lines
    function automatic logic pick(input ect_pkg::ect_src_t s, input ect_pkg::ect_edge_t e,
                                  input logic ar, input logic af, input logic br,
                                  input logic bf, input ect_pkg::ect_events_t ev,
                                  input logic td, input logic cd, input logic tk);
        logic r;
        r = 1'b0;
        unique case (s)
            ect_pkg::SRC_OFF:         r = 1'b0;
            ect_pkg::SRC_EXP_BEGIN:   r = ev.exposure_begin_event;
            ect_pkg::SRC_EXP_FINISH:  r = ev.exposure_finish_event;
            ect_pkg::SRC_RD_BEGIN:    r = ev.readout_begin_event;
            ect_pkg::SRC_RD_FINISH:   r = ev.readout_finish_event;
            ect_pkg::SRC_FRAME_BEGIN: r = ev.frame_begin_event;
            ect_pkg::SRC_FRAME_OK:    r = ev.accepted_frame_trigger;
            ect_pkg::SRC_INPUT_A:     r = (e != ect_pkg::EDGE_FALL && ar) ||
                                          (e != ect_pkg::EDGE_RISE && af);
            ect_pkg::SRC_INPUT_B:     r = (e != ect_pkg::EDGE_FALL && br) ||
                                          (e != ect_pkg::EDGE_RISE && bf);
            ect_pkg::SRC_TMR_DONE:    r = td;
            ect_pkg::SRC_CNT_DONE:    r = cd;
            ect_pkg::SRC_TICK:        r = tk;
            default:                  r = 1'b0;
        endcase
        return r;
    endfunction

    // source selection for counter and timer
    assign cnt_step      = pick(count_step_source, count_step_edge, a_rise, a_fall, b_rise,
                                b_fall, imaging_events, tmr_done_q, cnt_done_q,
                                tick_q);
    assign cnt_reset_evt = pick(count_clear_source, count_clear_edge, a_rise, a_fall,
                                b_rise, b_fall, imaging_events, tmr_done_q, cnt_at_limit,
                                1'b0); // counter end clears on the wrap itself
    assign cnt_begin_evt = pick(count_begin_source, ect_pkg::EDGE_RISE, a_rise, a_fall,
                                b_rise, b_fall, imaging_events, tmr_done_q, cnt_done_q,
                                1'b0);
    assign tmr_launch    = pick(tmr_launch_source, tmr_launch_edge, a_rise, a_fall,
                                b_rise, b_fall, imaging_events, tmr_done_q, cnt_done_q,
                                1'b0);

    assign self_restart = count_begin_source == ect_pkg::SRC_CNT_DONE;
    assign cnt_at_limit = counting_q && cnt_step && (count_now_q + 32'h1 >= count_limit_q);

    // control and limit registers; timer fields locked while enabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q             <= ect_pkg::CTRL_RST;
            count_limit_q      <= ect_pkg::LIMIT_RST;
            tmr_pulse_length_q <= 32'h0000_0000;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ect_pkg::OFS_CTRL) begin
                ctrl_q[15:0]             <= reg_req.wdata[15:0];
                ctrl_q[ect_pkg::F_TMR_EN] <= reg_req.wdata[ect_pkg::F_TMR_EN];
                ctrl_q[ect_pkg::F_CNT_EN] <= reg_req.wdata[ect_pkg::F_CNT_EN];
                if (!tmr_enable_setting) begin
                    ctrl_q[23:16] <= reg_req.wdata[23:16];
                end
            end
            if (reg_req.addr == ect_pkg::OFS_CNT_LIM) begin
                count_limit_q <= reg_req.wdata;
            end
            if (reg_req.addr == ect_pkg::OFS_TMR_LEN && !tmr_enable_setting) begin
                tmr_pulse_length_q <= reg_req.wdata;
            end
        end
    end

    // counter value, run flag and done pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_now_q <= 32'h0000_0000;
            counting_q  <= 1'b0;
            cnt_done_q  <= 1'b0;
        end else begin
            cnt_done_q <= 1'b0;
            if (!cnt_enable) begin
                counting_q <= 1'b0;
            end else if (count_clear_cmd) begin
                count_now_q <= 32'h0000_0000;
                counting_q  <= 1'b1;
            end else if (cnt_at_limit) begin
                cnt_done_q  <= 1'b1;
                count_now_q <= 32'h0000_0000;
                counting_q  <= self_restart;
            end else if (cnt_reset_evt && counting_q) begin
                count_now_q <= 32'h0000_0000;
                counting_q  <= 1'b0;
            end else if (!counting_q && (self_restart || cnt_begin_evt)) begin
                counting_q <= 1'b1;
            end else if (counting_q && cnt_step) begin
                count_now_q <= count_now_q + 32'h1;
            end
        end
    end

    // snapshot taken whenever the count is cleared
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_snapshot_q <= 32'h0000_0000;
        end else if (cnt_enable && (count_clear_cmd || cnt_at_limit ||
                                    (cnt_reset_evt && counting_q))) begin
            count_snapshot_q <= cnt_at_limit && !count_clear_cmd ? count_now_q + 32'h1
                                                                  : count_now_q;
        end
    end

    // timer state machine and elapsed microseconds
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tmr_state_q   <= ect_pkg::TMR_STATE_IDLE;
            tmr_elapsed_q <= 32'h0000_0000;
            tmr_done_q    <= 1'b0;
        end else begin
            tmr_done_q <= 1'b0;
            if (!tmr_enable_setting || tmr_launch_source == ect_pkg::SRC_OFF) begin
                tmr_state_q <= ect_pkg::TMR_STATE_IDLE;
                if (tmr_clear_cmd) begin
                    tmr_elapsed_q <= 32'h0000_0000;
                end
            end else begin
                unique case (tmr_state_q)
                    ect_pkg::TMR_STATE_IDLE: begin
                        tmr_state_q <= ect_pkg::TMR_STATE_ARMED;
                    end
                    ect_pkg::TMR_STATE_ARMED, ect_pkg::TMR_STATE_DONE: begin
                        if (tmr_launch) begin
                            tmr_elapsed_q <= 32'h0000_0000;
                            tmr_state_q   <= ect_pkg::TMR_STATE_RUNNING;
                        end
                    end
                    ect_pkg::TMR_STATE_RUNNING: begin
                        if (tmr_clear_cmd) begin
                            tmr_elapsed_q <= 32'h0000_0000;
                            tmr_state_q   <= ect_pkg::TMR_STATE_ARMED;
                        end else if (tmr_elapsed_q >= tmr_pulse_length_q) begin
                            tmr_state_q <= ect_pkg::TMR_STATE_DONE;
                            tmr_done_q  <= 1'b1;
                        end else if (tick_q) begin
                            tmr_elapsed_q <= tmr_elapsed_q + 32'h1;
                        end
                    end
                endcase
            end
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                ect_pkg::OFS_CTRL:     reg_rdata <= ctrl_q;
                ect_pkg::OFS_CNT_LIM:  reg_rdata <= count_limit_q;
                ect_pkg::OFS_CNT_NOW:  reg_rdata <= count_now_q;
                ect_pkg::OFS_CNT_SNAP: reg_rdata <= count_snapshot_q;
                ect_pkg::OFS_TMR_LEN:  reg_rdata <= tmr_pulse_length_q;
                ect_pkg::OFS_TMR_ELAP: reg_rdata <= tmr_elapsed_q;
                ect_pkg::OFS_STATUS:   reg_rdata <= {29'h0, counting_q, tmr_state_q};
                default:               reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    assign tmr_done_event   = tmr_done_q;
    assign count_done_event = cnt_done_q;
    assign tmr_pulse        = tmr_state_q == ect_pkg::TMR_STATE_RUNNING;

    // assertions
    a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
        tick_q |=> !tick_q [*8]) else $error("tick repeated too soon");
    a_clear_zeroes: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_enable && count_clear_cmd |=> count_now_q == 32'h0 && counting_q)
        else $error("clear did not zero and run");
    a_snap_capture: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_enable && count_clear_cmd |=> count_snapshot_q == $past(count_now_q))
        else $error("snapshot missed");
    a_step_off_hold: assert property (@(posedge ref_clk) disable iff (rst)
        count_step_source == ect_pkg::SRC_OFF && !count_clear_cmd && !cnt_at_limit
        && !cnt_reset_evt |=> $stable(count_now_q)) else $error("counted with step off");
    a_idle_when_off: assert property (@(posedge ref_clk) disable iff (rst)
        tmr_launch_source == ect_pkg::SRC_OFF |=> tmr_state_q == ect_pkg::TMR_STATE_IDLE)
        else $error("timer not idle with source off");
    a_tmr_lock: assert property (@(posedge ref_clk) disable iff (rst)
        tmr_enable_setting |=> $stable(tmr_pulse_length_q)) else $error("length changed");
    a_tmr_clear_arm: assert property (@(posedge ref_clk) disable iff (rst)
        tmr_enable_setting && tmr_launch_source != ect_pkg::SRC_OFF && tmr_clear_cmd
        && tmr_state_q == ect_pkg::TMR_STATE_RUNNING
        |=> tmr_state_q == ect_pkg::TMR_STATE_ARMED && tmr_elapsed_q == 32'h0)
        else $error("timer clear failed");
    a_tmr_complete: assert property (@(posedge ref_clk) disable iff (rst)
        tmr_done_q |-> tmr_state_q == ect_pkg::TMR_STATE_DONE
        && tmr_elapsed_q >= tmr_pulse_length_q) else $error("done without reaching length");
    a_self_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_enable && cnt_at_limit && self_restart && !count_clear_cmd
        |=> cnt_done_q && count_now_q == 32'h0 && counting_q) else $error("wrap failed");
    a_halt_on_reset: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_enable && counting_q && cnt_reset_evt && !count_clear_cmd && !cnt_at_limit
        |=> !counting_q && count_now_q == 32'h0) else $error("reset did not halt");

    // a launch seen while armed starts the timer from zero
    sequence s_armed_launch;
        tmr_enable_setting && tmr_launch_source != ect_pkg::SRC_OFF
        && tmr_state_q == ect_pkg::TMR_STATE_ARMED && tmr_launch;
    endsequence
    sequence s_running_zero;
        tmr_state_q == ect_pkg::TMR_STATE_RUNNING && tmr_elapsed_q == 32'h0;
    endsequence
    a_arm_launch: assert property (@(posedge ref_clk) disable iff (rst)
        s_armed_launch |=> s_running_zero) else $error("launch did not run timer");
    a_tmr_count_up: assert property (@(posedge ref_clk) disable iff (rst)
        tmr_enable_setting && tmr_launch_source != ect_pkg::SRC_OFF && tick_q
        && !tmr_clear_cmd && tmr_state_q == ect_pkg::TMR_STATE_RUNNING
        && tmr_elapsed_q < tmr_pulse_length_q
        |=> tmr_elapsed_q == $past(tmr_elapsed_q) + 32'h1) else $error("elapsed stuck");

endmodule

// ==== verif/ect_event_model.sv ====
// ect_event_model: stand-in for the imaging pipeline and the two input pins
// assumes the bench calls its tasks; every change lands just after a rising edge
`timescale 1ns/100ps

module ect_event_model (
    // clock
    input  wire logic            ref_clk,
    // event sources
    output ect_pkg::ect_events_t imaging_events,
    output logic                 io_input_a,
    output logic                 io_input_b
);
    // quiet at start: no event, both pins low
    initial begin
        imaging_events = '0;
        io_input_a     = 1'b0;
        io_input_b     = 1'b0;
    end

    // one-cycle pulse on one event, index 5 is exposure begin
    task automatic pulse(input logic [2:0] idx);
        @(posedge ref_clk);
        imaging_events <= ect_pkg::ect_events_t'(6'h01 << idx);
        @(posedge ref_clk);
        imaging_events <= '0;
    endtask

    // new level on pin a or pin b
    task automatic set_line(input logic b, input logic lv);
        @(posedge ref_clk);
        if (b) io_input_b <= lv;
        else io_input_a <= lv;
    endtask
endmodule

// ==== verif/testbench.sv ====
// testbench: scenario bench for the event counter and microsecond timer
// assumes ect_pkg, ect_core and ect_event_model are compiled before it
`timescale 1ns/100ps

module testbench;
    logic                  ref_clk = 1'b0;
    logic                  rst     = 1'b1;
    ect_pkg::ect_reg_req_t reg_req = '0;
    logic [31:0]           reg_rdata;
    ect_pkg::ect_events_t  imaging_events;
    logic                  io_input_a;
    logic                  io_input_b;
    logic                  tmr_done_event;
    logic                  count_done_event;
    logic                  tmr_pulse;
    int                    fail_count  = 0;
    int                    check_count = 0;
    logic [31:0]           v;
    int                    n;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    ect_core uut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .imaging_events(imaging_events), .io_input_a(io_input_a), .io_input_b(io_input_b),
        .tmr_done_event(tmr_done_event), .count_done_event(count_done_event),
        .tmr_pulse(tmr_pulse));
    ect_event_model src (.ref_clk(ref_clk), .imaging_events(imaging_events),
        .io_input_a(io_input_a), .io_input_b(io_input_b));

    // verdict and end of run
    task automatic results();
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // compare a word
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    // compare a value against a window
    task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] g);
        check_count++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            fail_count++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask

    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask

    // register read; data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        #1 v = reg_rdata;
        chk($sformatf("reg %h", a), e, v & m);
    endtask

    // bounded wait: 0 timer pulse, 1 timer done, 2 count done
    task automatic await(input int sel, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge ref_clk);
            #1;
            if ((sel == 0 && tmr_pulse === 1'b1) || (sel == 1 && tmr_done_event === 1'b1)
                || (sel == 2 && count_done_event === 1'b1)) return;
        end
        fail_count++;
        $display("FAIL wait %0d expected 1 seen 0", sel);
        results();
    endtask

    // reset values and an unmapped place
    task automatic sc_reset();
        rdc(ect_pkg::OFS_CTRL, '1, ect_pkg::CTRL_RST);
        rdc(ect_pkg::OFS_CNT_LIM, '1, ect_pkg::LIMIT_RST);
        rdc(8'h20, '1, 32'h0);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h0);
    endtask

    // clear starts counting and keeps old count, step off suspends
    task automatic sc_clear();
        wr(ect_pkg::OFS_CTRL, 32'h0200_0100);
        wr(ect_pkg::OFS_CMD, 32'h1);
        repeat (5) src.pulse(3'd5);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h5);
        wr(ect_pkg::OFS_CMD, 32'h1);
        rdc(ect_pkg::OFS_CNT_SNAP, '1, 32'h5);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h0);
        src.pulse(3'd5);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h1);
        wr(ect_pkg::OFS_CTRL, 32'h0200_0000);
        repeat (2) src.pulse(3'd5);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h1);
    endtask

    // exposure finish clears the count and halts until the next clear
    task automatic sc_event_clear();
        wr(ect_pkg::OFS_CTRL, 32'h0200_0120);
        wr(ect_pkg::OFS_CMD, 32'h1);
        repeat (3) src.pulse(3'd5);
        src.pulse(3'd4);
        rdc(ect_pkg::OFS_CNT_SNAP, '1, 32'h3);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h0);
        repeat (2) src.pulse(3'd5);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h0);
    endtask

    // microsecond tick as step source over about ten microseconds
    task automatic sc_tick();
        wr(ect_pkg::OFS_CNT_LIM, 32'h0000_1000);
        wr(ect_pkg::OFS_CTRL, 32'h0200_0b00);
        wr(ect_pkg::OFS_CMD, 32'h1);
        repeat (400) @(posedge ref_clk);
        rdc(ect_pkg::OFS_CNT_NOW, 32'hffff_fff0, 32'h0);
        chk_rng("tick count", 9, 11, v);
    endtask

    // self restarting counter with a limit of three
    task automatic sc_limit();
        wr(ect_pkg::OFS_CTRL, 32'h0200_0000);
        wr(ect_pkg::OFS_CMD, 32'h1);
        wr(ect_pkg::OFS_CTRL, 32'h0);
        wr(ect_pkg::OFS_CNT_LIM, 32'h3);
        wr(ect_pkg::OFS_CTRL, 32'h0200_01aa);
        repeat (2) src.pulse(3'd5);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h2);
        fork
            src.pulse(3'd5);
            await(2, 10);
        join
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h0);
        rdc(ect_pkg::OFS_CNT_SNAP, '1, 32'h3);
        src.pulse(3'd5);
        wr(ect_pkg::OFS_CMD, 32'h1);
        src.pulse(3'd5);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h1);
    endtask

    // timer on rising edge of pin a, length two microseconds
    task automatic sc_timer();
        wr(ect_pkg::OFS_TMR_LEN, 32'h2);
        wr(ect_pkg::OFS_CTRL, 32'h0107_0000);
        wr(ect_pkg::OFS_TMR_LEN, 32'h5);
        rdc(ect_pkg::OFS_TMR_LEN, '1, 32'h2);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h1);
        src.set_line(1'b0, 1'b1);
        await(0, 8);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h2);
        await(1, 120);
        chk_rng("pulse cycles", 30, 90, n);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h3);
        rdc(ect_pkg::OFS_TMR_ELAP, '1, 32'h2);
        src.set_line(1'b0, 1'b0);
        repeat (4) @(posedge ref_clk);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h3);
        src.set_line(1'b0, 1'b1);
        await(0, 8);
        wr(ect_pkg::OFS_CMD, 32'h2);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h1);
        rdc(ect_pkg::OFS_TMR_ELAP, '1, 32'h0);
        wr(ect_pkg::OFS_CTRL, 32'h0);
        wr(ect_pkg::OFS_CTRL, 32'h0100_0000);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h0);
    endtask

    // each imaging source launches the timer, then pin b on a falling edge
    task automatic sc_sources();
        for (int s = 1; s <= 6; s++) begin
            wr(ect_pkg::OFS_CTRL, 32'h0);
            wr(ect_pkg::OFS_CTRL, 32'h0100_0000 | (32'(s) << 16));
            src.pulse(3'(6 - s));
            await(0, 8);
        end
        wr(ect_pkg::OFS_CTRL, 32'h0);
        wr(ect_pkg::OFS_CTRL, 32'h0118_0000);
        src.set_line(1'b1, 1'b1);
        repeat (4) @(posedge ref_clk);
        rdc(ect_pkg::OFS_STATUS, 32'h3, 32'h1);
        src.set_line(1'b1, 1'b0);
        await(0, 8);
    endtask

    // pin a steps on any edge, a falling pin b clears and halts
    task automatic sc_line_clear();
        wr(ect_pkg::OFS_CTRL, 32'h0200_9780);
        wr(ect_pkg::OFS_CMD, 32'h1);
        src.set_line(1'b0, 1'b0);
        repeat (4) @(posedge ref_clk);
        src.set_line(1'b0, 1'b1);
        src.set_line(1'b1, 1'b1);
        repeat (4) @(posedge ref_clk);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h2);
        src.set_line(1'b1, 1'b0);
        repeat (4) @(posedge ref_clk);
        rdc(ect_pkg::OFS_CNT_SNAP, '1, 32'h2);
        rdc(ect_pkg::OFS_CNT_NOW, '1, 32'h0);
    endtask

    // reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        sc_reset();
        sc_clear();
        sc_event_clear();
        sc_tick();
        sc_limit();
        sc_timer();
        sc_sources();
        sc_line_clear();
        results();
    end
endmodule
